// >>> mcrs_consts.svh
// timing counts, register offsets, field positions and reset values of the reset sequencer
// included by the sequencer top module and its testbench; core clock assumed 100 MHz
`ifndef MCRS_CONSTS_SVH
`define MCRS_CONSTS_SVH

`define MCRS_CLK_MHZ      32'd100
`define MCRS_HOLD_MS      32'd32
`define MCRS_DELAY_MS     32'd10
`define MCRS_HOLD_CYC     (`MCRS_HOLD_MS * 32'd1000 * `MCRS_CLK_MHZ)
`define MCRS_DELAY_CYC    (`MCRS_DELAY_MS * 32'd1000 * `MCRS_CLK_MHZ)

`define MCRS_PULSES       4'h8
`define MCRS_SEL_FALLS    2'h2
`define MCRS_SYNC_FIRST   4'h1
`define MCRS_SYNC_LAST    4'h4

`define MCRS_ADDR_STATUS_REGISTER_ONE 16'hE501
`define MCRS_ADDR_CFG     16'hE510
`define MCRS_ADDR_CFG2    16'hE511
`define MCRS_ADDR_RUN     16'hE512
`define MCRS_ADDR_KEY     16'hE7FE
`define MCRS_ADDR_STEP2   16'hE7E3

`define MCRS_BIT_RESET_DONE_FLAG  15
`define MCRS_BIT_SOFTWARE_RESET_BIT    7
`define MCRS_BIT_LOCK     0

`define MCRS_KEY_VAL      8'hAD
`define MCRS_STEP2_VAL    8'h80
`define MCRS_RUN_VAL      16'h0001
`define MCRS_CFG_RST      16'h0000
`define MCRS_CFG_SOFTWARE_RESET_BIT    16'h0080

`endif

// >>> mcrs_pkg.sv
// types shared by the reset sequencer files
// no assumptions beyond a SystemVerilog compiler
package mcrs_pkg;

   typedef enum logic [2:0] {
      S_OFF,
      S_HOLD,
      S_DELAY,
      S_PULSE_ON,
      S_PINRST,
      S_PULSE_OFF,
      S_RUN
   } mcrs_state_e;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mcrs_req_s;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } mcrs_rsp_s;

   typedef struct packed {
      logic frontend_clock_out;
      logic sync;
      logic reset_en;
      logic phase_a_reset_line;
      logic phase_b_reset_line;
      logic phase_c_reset_line;
      logic neutral_reset_line;
   } mcrs_fe_s;

endpackage : mcrs_pkg

// >>> mcrs_timer.sv
// cycle timer: counts core cycles while enabled, done level after the limit
// assumes a synchronous active-low reset and a limit of at least one
`timescale 1ns/10ps
`default_nettype none

module mcrs_timer #(
   parameter int W = 32
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_en,
   input  wire logic [W-1:0] i_limit,
   output var  logic         o_done
);

   logic [W-1:0] cnt_q;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n || !i_en) begin
         cnt_q <= '0;
      end else if (!o_done) begin
         cnt_q <= cnt_q + W'(1);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n || !i_en) begin
         o_done <= 1'b0;
      end else if (cnt_q == i_limit - W'(1)) begin
         o_done <= 1'b1;
      end
   end

   a_timer_count: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(o_done) |-> cnt_q == i_limit && $past(i_en))
      else $error("timer done without full count");

endmodule : mcrs_timer

`default_nettype wire

// >>> mcrs_top.sv
// reset and start-up sequencer: power hold, front-end clock, reset pulse train,
// port selection and lock, reset-done flag, processor run and protect control
// assumes a 100 MHz core clock, synchronous active-low reset pin, a supply-good level
`timescale 1ns/10ps
`default_nettype none
`include "mcrs_consts.svh"

module mcrs_top #(
   parameter int unsigned HOLD_CYC  = `MCRS_HOLD_CYC,
   parameter int unsigned DELAY_CYC = `MCRS_DELAY_CYC
) (
   input  wire logic                i_core_clk,
   input  wire logic                i_rst_n,
   input  wire logic                i_supply_ok,
   input  wire logic                i_select_handshake_pin,
   input  wire mcrs_pkg::mcrs_req_s i_req,
   output var  mcrs_pkg::mcrs_rsp_s o_rsp,
   output var  mcrs_pkg::mcrs_fe_s  o_fe,
   output var  logic                o_interrupt_one_pin_n,
   output var  logic                o_spi_active,
   output var  logic                o_port_locked,
   output var  logic                o_dsp_run,
   output var  logic                o_dsp_protect
);

   mcrs_pkg::mcrs_state_e st_q;
   mcrs_pkg::mcrs_state_e st_d;

   logic [3:0]  div_q;
   logic [3:0]  pcnt_q;
   logic [1:0]  falls_q;
   logic [15:0] cfg_q;
   logic [15:0] rd_data;
   logic        hold_done;
   logic        delay_done;
   logic        sel_q;
   logic        spi_q;
   logic        lock_q;
   logic        reset_done_flag_q;
   logic        reset_done_flag_d;
   logic        run_q;
   logic        key_armed_q;
   logic        protect_q;
   logic        lines_d;
   logic        in_pulse;
   logic        clk_en;
   logic        seq_end;
   logic        sel_fall;
   logic        port_clr;
   logic        sw_start;
   logic        regs_clr;
   logic        wr_st1;
   logic        wr_cfg;
   logic        wr_cfg2;
   logic        wr_run;
   logic        wr_key;
   logic        wr_step2;

   // write decode
   assign wr_st1   = i_req.wr && (i_req.addr == `MCRS_ADDR_STATUS_REGISTER_ONE);
   assign wr_cfg   = i_req.wr && (i_req.addr == `MCRS_ADDR_CFG);
   assign wr_cfg2  = i_req.wr && (i_req.addr == `MCRS_ADDR_CFG2);
   assign wr_run   = i_req.wr && (i_req.addr == `MCRS_ADDR_RUN);
   assign wr_key   = i_req.wr && (i_req.addr == `MCRS_ADDR_KEY);
   assign wr_step2 = i_req.wr && (i_req.addr == `MCRS_ADDR_STEP2);

   assign in_pulse = (st_q == mcrs_pkg::S_PULSE_ON) || (st_q == mcrs_pkg::S_PULSE_OFF);
   assign clk_en   = (st_q == mcrs_pkg::S_DELAY) || (st_q == mcrs_pkg::S_PULSE_ON) ||
                     (st_q == mcrs_pkg::S_RUN);
   assign seq_end  = in_pulse && (pcnt_q == `MCRS_PULSES) && (div_q[1:0] == 2'h3);
   assign port_clr = !i_rst_n || !i_supply_ok;
   assign sw_start = (st_q == mcrs_pkg::S_RUN) && wr_cfg && i_req.wdata[`MCRS_BIT_SOFTWARE_RESET_BIT];
   assign regs_clr = port_clr || sw_start;
   assign sel_fall = sel_q && !i_select_handshake_pin;
   assign lines_d  = in_pulse ? ~div_q[1] : 1'b1;

   // delay timers
   mcrs_timer #(.W(32)) u_hold (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_en       (st_q == mcrs_pkg::S_HOLD),
      .i_limit    (HOLD_CYC),
      .o_done     (hold_done)
   );

   mcrs_timer #(.W(32)) u_delay (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_en       (st_q == mcrs_pkg::S_DELAY),
      .i_limit    (DELAY_CYC),
      .o_done     (delay_done)
   );

   // sequence state
   always_comb begin
      st_d = st_q;
      case (st_q)
         mcrs_pkg::S_OFF:       if (i_supply_ok) st_d = mcrs_pkg::S_HOLD;
         mcrs_pkg::S_HOLD:      if (hold_done) st_d = mcrs_pkg::S_DELAY;
         mcrs_pkg::S_DELAY:     if (delay_done) st_d = mcrs_pkg::S_PULSE_ON;
         mcrs_pkg::S_PINRST:    st_d = mcrs_pkg::S_PULSE_OFF;
         mcrs_pkg::S_PULSE_ON:  if (seq_end) st_d = mcrs_pkg::S_RUN;
         mcrs_pkg::S_PULSE_OFF: if (seq_end) st_d = mcrs_pkg::S_RUN;
         mcrs_pkg::S_RUN:       if (sw_start) st_d = mcrs_pkg::S_PULSE_ON;
         default:               st_d = mcrs_pkg::S_OFF;
      endcase
      if (!i_supply_ok) begin
         st_d = mcrs_pkg::S_OFF;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         st_q <= mcrs_pkg::S_PINRST;
      end else begin
         st_q <= st_d;
      end
   end

   // free-running divider: bits 1:0 give clock over four, all four over sixteen
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         div_q <= 4'h0;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end

   // falling edges of the reset lines
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n || !in_pulse) begin
         pcnt_q <= 4'h0;
      end else if (o_fe.phase_a_reset_line && !lines_d) begin
         pcnt_q <= pcnt_q + 4'h1;
      end
   end

   // front-end pins
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_fe <= '1;
      end else begin
         o_fe.frontend_clock_out <= clk_en ? ~div_q[1] : 1'b1;
         o_fe.sync               <= clk_en ? (div_q >= `MCRS_SYNC_FIRST && div_q <= `MCRS_SYNC_LAST)
                                           : 1'b1;
         o_fe.reset_en           <= !in_pulse;
         o_fe.phase_a_reset_line <= lines_d;
         o_fe.phase_b_reset_line <= lines_d;
         o_fe.phase_c_reset_line <= lines_d;
         o_fe.neutral_reset_line <= lines_d;
      end
   end

   // serial port selection and lock
   always_ff @(posedge i_core_clk) begin
      if (port_clr) begin
         sel_q <= 1'b1;
      end else begin
         sel_q <= i_select_handshake_pin;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (port_clr) begin
         spi_q   <= 1'b0;
         falls_q <= 2'h0;
      end else if (!lock_q && !spi_q && sel_fall) begin
         if (falls_q == `MCRS_SEL_FALLS) begin
            spi_q <= 1'b1;
         end else begin
            falls_q <= falls_q + 2'h1;
         end
      end
   end

   // not cleared by software reset
   always_ff @(posedge i_core_clk) begin
      if (port_clr) begin
         lock_q <= 1'b0;
      end else if (wr_cfg2 && spi_q) begin
         lock_q <= 1'b1;
      end else if (wr_cfg2 && i_req.wdata[`MCRS_BIT_LOCK]) begin
         lock_q <= 1'b1;
      end
   end

   // reset-done flag, set wins over write and software-reset clear
   always_comb begin
      reset_done_flag_d = reset_done_flag_q;
      if (port_clr) begin
         reset_done_flag_d = 1'b0;
      end else if (seq_end) begin
         reset_done_flag_d = 1'b1;
      end else if (sw_start || (wr_st1 && i_req.wdata[`MCRS_BIT_RESET_DONE_FLAG])) begin
         reset_done_flag_d = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      reset_done_flag_q <= reset_done_flag_d;
      o_interrupt_one_pin_n  <= !reset_done_flag_d;
   end

   // configuration register, software-reset bit self-clears
   always_ff @(posedge i_core_clk) begin
      if (port_clr) begin
         cfg_q <= `MCRS_CFG_RST;
      end else if (sw_start) begin
         cfg_q <= `MCRS_CFG_SOFTWARE_RESET_BIT;
      end else if (seq_end) begin
         cfg_q[`MCRS_BIT_SOFTWARE_RESET_BIT] <= 1'b0;
      end else if (wr_cfg) begin
         cfg_q <= {i_req.wdata[15:8], cfg_q[`MCRS_BIT_SOFTWARE_RESET_BIT], i_req.wdata[6:0]};
      end
   end

   // processor run control
   always_ff @(posedge i_core_clk) begin
      if (regs_clr) begin
         run_q <= 1'b0;
      end else if (wr_run && st_q == mcrs_pkg::S_RUN) begin
         run_q <= (i_req.wdata == `MCRS_RUN_VAL);
      end
   end

   // processor RAM write protection
   always_ff @(posedge i_core_clk) begin
      if (regs_clr) begin
         key_armed_q <= 1'b0;
         protect_q   <= 1'b0;
      end else if (wr_key) begin
         key_armed_q <= (i_req.wdata[7:0] == `MCRS_KEY_VAL);
      end else if (wr_step2) begin
         key_armed_q <= 1'b0;
         if (key_armed_q && i_req.wdata[7:0] == `MCRS_STEP2_VAL) begin
            protect_q <= 1'b1;
         end
      end
   end

   // read port
   always_comb begin
      rd_data = 16'h0000;
      case (i_req.addr)
         `MCRS_ADDR_STATUS_REGISTER_ONE: rd_data[`MCRS_BIT_RESET_DONE_FLAG] = reset_done_flag_q;
         `MCRS_ADDR_CFG:     rd_data = cfg_q;
         `MCRS_ADDR_CFG2:    rd_data[`MCRS_BIT_LOCK] = lock_q;
         `MCRS_ADDR_RUN:     rd_data[0] = run_q;
         default:            rd_data = 16'h0000;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_rsp <= '0;
      end else begin
         o_rsp.valid <= i_req.rd;
         o_rsp.data  <= i_req.rd ? rd_data : 16'h0000;
      end
   end

   assign o_spi_active  = spi_q;
   assign o_port_locked = lock_q;
   assign o_dsp_run     = run_q;
   assign o_dsp_protect = protect_q;

   // checks
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n || !i_supply_ok);

   sequence sync_high4;
      o_fe.sync [*4] ##1 !o_fe.sync;
   endsequence

   sequence clk_half_cycle;
      o_fe.frontend_clock_out ##2 !o_fe.frontend_clock_out;
   endsequence

   a_hold_then_delay: assert property (
      $rose(st_q == mcrs_pkg::S_DELAY) |-> $past(st_q) == mcrs_pkg::S_HOLD && $past(hold_done))
      else $error("front-end clock started before hold time");

   a_clk_runs: assert property (
      st_q == mcrs_pkg::S_RUN && div_q[1:0] == 2'h0 |=> clk_half_cycle)
      else $error("front-end clock not divided by four");

   a_pulse_eight: assert property (
      $rose(st_q == mcrs_pkg::S_RUN) |-> $past(pcnt_q) == `MCRS_PULSES && $past(!o_fe.reset_en))
      else $error("reset pulse train not eight pulses");

   a_port_switch: assert property (
      !lock_q && !spi_q && falls_q == `MCRS_SEL_FALLS && sel_fall |=> spi_q)
      else $error("third select fall did not pick SPI");

   a_lock_keeps: assert property (
      lock_q && !spi_q |=> lock_q && !spi_q)
      else $error("locked I2C port changed");

   a_software_reset_bit_keeps: assert property (
      sw_start && !sel_fall |=> spi_q == $past(spi_q) && lock_q == $past(lock_q))
      else $error("software reset changed port choice");

   a_reset_done_flag_set: assert property (
      $rose(st_q == mcrs_pkg::S_RUN) |-> reset_done_flag_q && !o_interrupt_one_pin_n && !cfg_q[`MCRS_BIT_SOFTWARE_RESET_BIT])
      else $error("reset-done not flagged at sequence end");

   a_irq_follows: assert property (
      o_interrupt_one_pin_n == !reset_done_flag_q)
      else $error("interrupt-one disagrees with reset-done");

   a_run_idle: assert property (
      st_q != mcrs_pkg::S_RUN |-> !o_dsp_run)
      else $error("processor running outside run state");

   a_protect_order: assert property (
      $rose(protect_q) |-> $past(key_armed_q) && $past(wr_step2))
      else $error("protection set without key order");

   a_pin_reset: assert property (@(posedge i_core_clk) disable iff (1'b0)
      !i_rst_n |=> o_fe == '1)
      else $error("front-end pins not high in pin reset");

   a_hw_no_clk: assert property (
      st_q == mcrs_pkg::S_PULSE_OFF && st_d == mcrs_pkg::S_PULSE_OFF
      |=> o_fe.frontend_clock_out && !o_fe.reset_en)
      else $error("front-end clock ran during pin-reset pulses");

   a_sw_clk: assert property (
      st_q == mcrs_pkg::S_PULSE_ON && div_q[1:0] == 2'h2 |=> !o_fe.frontend_clock_out)
      else $error("front-end clock stopped during software reset");

   a_sync_duty: assert property (
      $rose(o_fe.sync) && st_q == mcrs_pkg::S_RUN |-> sync_high4)
      else $error("sync not high for four core cycles");

endmodule : mcrs_top

`default_nettype wire

// >>> mcrs_fe_model.sv
// front-end model: counts reset-line falls and clock falls in each reset-enable low phase
// assumes the sequencer's front-end output struct and the core clock
`timescale 1ns/10ps
`default_nettype none

module mcrs_fe_model (
   input  wire logic               i_core_clk,
   input  wire mcrs_pkg::mcrs_fe_s i_fe,
   output var  logic [7:0]         o_line_falls,
   output var  logic [7:0]         o_clk_falls
);
   mcrs_pkg::mcrs_fe_s fe_q;
   logic               line_fall;
   logic               clk_fall;
   logic               train_start;

   // all four lines must fall together
   assign line_fall   = (fe_q[3:0] == 4'hF) && (i_fe[3:0] == 4'h0);
   assign clk_fall    = fe_q.frontend_clock_out && !i_fe.frontend_clock_out;
   assign train_start = fe_q.reset_en && !i_fe.reset_en;

   always @(posedge i_core_clk) begin
      fe_q <= i_fe;
   end

   always @(posedge i_core_clk) begin
      if (train_start) begin
         o_line_falls <= {7'h00, line_fall};
      end else if (!i_fe.reset_en && line_fall) begin
         o_line_falls <= o_line_falls + 8'h01;
      end
   end

   always @(posedge i_core_clk) begin
      if (train_start) begin
         o_clk_falls <= {7'h00, clk_fall};
      end else if (!i_fe.reset_en && clk_fall) begin
         o_clk_falls <= o_clk_falls + 8'h01;
      end
   end
endmodule : mcrs_fe_model
`default_nettype wire

// >>> mcrs_top_tb.sv
// self-checking testbench of the reset sequencer: host register tasks and directed tests
// assumes mcrs_pkg, mcrs_top and mcrs_fe_model are compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "mcrs_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module mcrs_top_tb;
   localparam int HOLD  = 20;
   localparam int DELAY = 10;
   logic                core_clk  = 1'b0;
   logic                rst_n     = 1'b0;
   logic                supply_ok = 1'b1;
   logic                sel       = 1'b1;
   mcrs_pkg::mcrs_req_s req       = '0;
   mcrs_pkg::mcrs_rsp_s rsp;
   mcrs_pkg::mcrs_fe_s  fe;
   logic                interrupt_one_pin_n;
   logic                spi;
   logic                locked;
   logic                run;
   logic                protect;
   logic [7:0]          line_falls;
   logic [7:0]          clk_falls;
   logic                prev_clk;
   int                  n_mismatch      = 0;
   int                  samples_checked = 0;
   int                  n;
   int                  m;

   always #5 core_clk = ~core_clk;

   mcrs_top #(.HOLD_CYC(HOLD), .DELAY_CYC(DELAY)) u_mcrs_top (
      .i_core_clk             (core_clk),
      .i_rst_n                (rst_n),
      .i_supply_ok            (supply_ok),
      .i_select_handshake_pin (sel),
      .i_req                  (req),
      .o_rsp                  (rsp),
      .o_fe                   (fe),
      .o_interrupt_one_pin_n               (interrupt_one_pin_n),
      .o_spi_active           (spi),
      .o_port_locked          (locked),
      .o_dsp_run              (run),
      .o_dsp_protect          (protect)
   );

   mcrs_fe_model u_mcrs_fe_model (
      .i_core_clk   (core_clk),
      .i_fe         (fe),
      .o_line_falls (line_falls),
      .o_clk_falls  (clk_falls)
   );

   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask : cyc

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      cyc(1);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      cyc(1);
      req = '0;
   endtask : wr

   task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
      cyc(1);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      cyc(1);
      req = '0;
      `CHK(rsp.valid, 1'b1)
      `CHK(rsp.data, e)
   endtask : rdchk

   task automatic wait_irq();
      n = 0;
      while (interrupt_one_pin_n !== 1'b0 && n < 400) begin
         cyc(1);
         n++;
      end
      `CHK(interrupt_one_pin_n, 1'b0)
   endtask : wait_irq

   task automatic sel_falls(input int k);
      repeat (k) begin
         cyc(1);
         sel = 1'b0;
         cyc(1);
         sel = 1'b1;
      end
      cyc(2);
   endtask : sel_falls

   task automatic test_end(input string s);
      $display("test %s finished, mismatches so far %0d", s, n_mismatch);
   endtask : test_end

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   initial begin
      #200000;
      n_mismatch++;
      test_done();
   end

   initial begin
      cyc(3);
      `CHK(fe, 7'h7F)
      `CHK(interrupt_one_pin_n, 1'b1)
      cyc(5);
      rst_n = 1'b1;
      wait_irq();
      `CHK(line_falls, 8'h08)
      `CHK(clk_falls, 8'h00)
      rdchk(`MCRS_ADDR_STATUS_REGISTER_ONE, 16'h8000);
      wr(`MCRS_ADDR_STATUS_REGISTER_ONE, 16'h8000);
      cyc(1);
      `CHK(interrupt_one_pin_n, 1'b1)
      rdchk(`MCRS_ADDR_STATUS_REGISTER_ONE, 16'h0000);
      rdchk(`MCRS_ADDR_RUN, 16'h0000);
      `CHK(spi, 1'b0)
      test_end("pin_reset");

      sel_falls(3);
      `CHK(spi, 1'b1)
      wr(`MCRS_ADDR_CFG2, 16'h0000);
      cyc(1);
      `CHK(locked, 1'b1)
      wr(`MCRS_ADDR_RUN, `MCRS_RUN_VAL);
      wr(`MCRS_ADDR_CFG, `MCRS_CFG_SOFTWARE_RESET_BIT);
      rdchk(`MCRS_ADDR_CFG, 16'h0080);
      `CHK(fe.reset_en, 1'b0)
      `CHK(interrupt_one_pin_n, 1'b1)
      wait_irq();
      `CHK(line_falls, 8'h08)
      `CHK(clk_falls > 8'h00, 1'b1)
      cyc(1);
      `CHK(fe[4:0], 5'h1F)
      rdchk(`MCRS_ADDR_CFG, 16'h0000);
      `CHK({spi, locked}, 2'b11)
      `CHK(run, 1'b0)
      wr(`MCRS_ADDR_STATUS_REGISTER_ONE, 16'h8000);
      test_end("soft_reset");

      cyc(1);
      rst_n = 1'b0;
      cyc(1000);
      `CHK({spi, locked}, 2'b00)
      rst_n = 1'b1;
      wait_irq();
      wr(`MCRS_ADDR_STATUS_REGISTER_ONE, 16'h8000);
      wr(`MCRS_ADDR_CFG2, 16'h0001);
      cyc(1);
      `CHK(locked, 1'b1)
      sel_falls(3);
      `CHK(spi, 1'b0)
      test_end("lock_i2c");

      repeat (3) wr(16'h43BF, 16'h0000);
      rdchk(16'h4380, 16'h0000);
      wr(`MCRS_ADDR_STEP2, 16'h0080);
      cyc(1);
      `CHK(protect, 1'b0)
      wr(`MCRS_ADDR_KEY, 16'h00AD);
      wr(`MCRS_ADDR_STEP2, 16'h0080);
      cyc(1);
      `CHK(protect, 1'b1)
      rdchk(`MCRS_ADDR_KEY, 16'h0000);
      wr(`MCRS_ADDR_RUN, 16'h0001);
      cyc(1);
      `CHK(run, 1'b1)
      wr(`MCRS_ADDR_RUN, 16'h0002);
      cyc(1);
      `CHK(run, 1'b0)
      test_end("protect_run");

      n = 0;
      m = 0;
      prev_clk = fe.frontend_clock_out;
      repeat (32) begin
         cyc(1);
         m += int'(fe.sync);
         n += int'(fe.frontend_clock_out != prev_clk);
         prev_clk = fe.frontend_clock_out;
      end
      `CHK(m, 8)
      `CHK(n, 16)
      test_end("sync_clock");

      wr(`MCRS_ADDR_RUN, 16'h0001);
      supply_ok = 1'b0;
      cyc(3);
      `CHK(fe, 7'h7F)
      `CHK({spi, locked, run}, 3'b000)
      supply_ok = 1'b1;
      n = 0;
      while (fe.frontend_clock_out === 1'b1 && n < 300) begin
         cyc(1);
         n++;
      end
      `CHK(n >= HOLD && n <= HOLD + 8, 1'b1)
      m = 0;
      while (fe.reset_en === 1'b1 && m < 300) begin
         cyc(1);
         m++;
      end
      `CHK(m >= DELAY - 4 && m <= DELAY + 6, 1'b1)
      wait_irq();
      `CHK(line_falls, 8'h08)
      `CHK(clk_falls > 8'h00, 1'b1)
      rdchk(`MCRS_ADDR_STATUS_REGISTER_ONE, 16'h8000);
      rdchk(`MCRS_ADDR_CFG, 16'h0000);
      test_end("power_up");

      rst_n = 1'b0;
      cyc(1000);
      `CHK(fe, 7'h7F)
      rst_n = 1'b1;
      sel_falls(3);
      `CHK(spi, 1'b1)
      wait_irq();
      `CHK(line_falls, 8'h08)
      test_end("spi_reselect");
      test_done();
   end
endmodule : mcrs_top_tb
`default_nettype wire
